/* src/trl_pkg.sv */
// trl_pkg: register map, field layout and reset values of the reload timers.
// assumes byte addressing on a 32-bit apb bus, one aligned word per register.
`default_nettype none

package trl_pkg;

  // bus geometry
  localparam int unsigned TRL_ADDR_W    = 13;
  localparam int unsigned TRL_DATA_W    = 32;
  localparam int unsigned TRL_IDX_W     = 2;
  localparam int unsigned TRL_MAX_TIMERS = 4;

  // register offsets of timer 0, later timers follow at a fixed stride
  localparam logic [12:0] TRL_OFS_CUR0  = 13'h1100;
  localparam logic [12:0] TRL_OFS_BASE0 = 13'h1110;
  localparam logic [12:0] TRL_OFS_VP0   = 13'h1120;
  localparam logic [12:0] TRL_STRIDE    = 13'h0040;

  // register kinds inside one timer's window (offset bits 5:4)
  localparam logic [1:0] TRL_KIND_CUR  = 2'h0;
  localparam logic [1:0] TRL_KIND_BASE = 2'h1;
  localparam logic [1:0] TRL_KIND_VP   = 2'h2;

  // field layout
  localparam int unsigned TRL_COUNT_W    = 31;
  localparam int unsigned TRL_HOLD_BIT   = 31;
  localparam int unsigned TRL_TOGGLE_BIT = 31;
  localparam int unsigned TRL_MASK_BIT   = 31;
  localparam int unsigned TRL_ACT_BIT    = 30;
  localparam int unsigned TRL_LEVEL_LSB  = 16;
  localparam int unsigned TRL_LEVEL_W    = 4;
  localparam int unsigned TRL_VEC_LSB    = 0;
  localparam int unsigned TRL_VEC_W      = 8;

  // reset values
  localparam logic        TRL_HOLD_RST   = 1'b0;
  localparam logic [30:0] TRL_RELOAD_RST = 31'h00000000;
  localparam logic        TRL_MASK_RST   = 1'b1;
  localparam logic [3:0]  TRL_LEVEL_RST  = 4'h0;
  localparam logic [7:0]  TRL_VEC_RST    = 8'h00;

  // decoded register access
  typedef struct packed {
    logic                 hit;
    logic [TRL_IDX_W-1:0] idx;
    logic [1:0]           kind;
  } trl_dec_t;

endpackage : trl_pkg

`default_nettype wire

/* src/trl_chan_if.sv */
// trl_chan_if: control and status between the register block and one timer channel.
// assumes both ends run on the same pclk.
`default_nettype none

interface trl_chan_if;
  logic        hold;
  logic [30:0] reload;
  logic        load;
  logic [30:0] count;
  logic        toggle;
  logic        expire;

  modport ctl  (output hold, output reload, output load,
                input  count, input toggle, input expire);
  modport chan (input  hold, input reload, input load,
                output count, output toggle, output expire);
endinterface : trl_chan_if

`default_nettype wire

/* src/trl_timer_chan.sv */
// trl_timer_chan: one down-counting timer with reload and toggle status.
// assumes tick is a one-cycle enable from logic on pclk.
`default_nettype none

module trl_timer_chan
  import trl_pkg::*;
(
  // clock and reset
  input  wire logic pclk,
  input  wire logic presetn,
  // count enable
  input  wire logic tick,
  // register side
  trl_chan_if.chan  ch
);

  logic [30:0] count;
  logic        toggle;
  logic        expire;
  logic [30:0] next_count;
  logic        next_toggle;
  logic        next_expire;

  always_comb begin
    next_count  = count;
    next_toggle = toggle;
    next_expire = 1'b0;
    if (ch.load) begin
      next_count  = ch.reload;
      next_toggle = 1'b0;
    end else if (!ch.hold && tick) begin
      // reaching zero reloads in the same tick, so the period is reload ticks
      if (count <= 31'h00000001) begin
        next_count  = ch.reload;
        next_toggle = ~toggle;
        next_expire = 1'b1;
      end else begin
        next_count = count - 31'h00000001;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      count  <= 31'h00000000;
      toggle <= 1'b0;
      expire <= 1'b0;
    end else begin
      count  <= next_count;
      toggle <= next_toggle;
      expire <= next_expire;
    end
  end

  assign ch.count  = count;
  assign ch.toggle = toggle;
  assign ch.expire = expire;

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  property p_hold_freezes;
    ch.hold && !ch.load |=> $stable(count) && !expire;
  endproperty
  a_hold_freezes: assert property (p_hold_freezes) else $error("count moved while held");

  property p_decrement;
    !ch.hold && !ch.load && tick && count > 31'h00000001 |=> count == $past(count) - 31'h00000001;
  endproperty
  a_decrement: assert property (p_decrement) else $error("count did not step down by one");

  sequence s_wrap_cause;
    !ch.hold && !ch.load && tick && count <= 31'h00000001;
  endsequence
  property p_wrap;
    s_wrap_cause |=> expire && count == $past(ch.reload) && toggle != $past(toggle);
  endproperty
  a_wrap: assert property (p_wrap) else $error("zero did not reload, toggle and expire");

endmodule : trl_timer_chan

`default_nettype wire

/* src/trl_timer_block.sv */
// trl_timer_block: apb register file for up to four reload timers and their interrupt sources.
// assumes the surrounding controller takes irq_req, acknowledges by index and ends service by index.
//
// Implementation choices: register access over APB and the placing of the registers.
`default_nettype none

module trl_timer_block
  import trl_pkg::*;
#(
  parameter int unsigned NUM_TIMERS = 4
) (
  // apb clock and reset
  input  wire logic                   pclk,
  input  wire logic                   presetn,
  // apb slave
  input  wire logic                   psel,
  input  wire logic                   penable,
  input  wire logic                   pwrite,
  input  wire logic [TRL_ADDR_W-1:0]  paddr,
  input  wire logic [TRL_DATA_W-1:0]  pwdata,
  output logic      [TRL_DATA_W-1:0]  prdata,
  output logic                        pready,
  output logic                        pslverr,
  // timer tick enable
  input  wire logic                   tick,
  // requests to the interrupt controller
  output logic      [NUM_TIMERS-1:0]  irq_req,
  output logic                        irq_best_valid,
  output logic      [TRL_IDX_W-1:0]   irq_best_idx,
  output logic      [3:0]             irq_best_level,
  // acknowledge and end of service from the controller
  input  wire logic                   ack_valid,
  input  wire logic [TRL_IDX_W-1:0]   ack_idx,
  input  wire logic                   eoi_valid,
  input  wire logic [TRL_IDX_W-1:0]   eoi_idx,
  output logic                        ack_done,
  output logic      [7:0]             ack_vector
);

  if (NUM_TIMERS < 1 || NUM_TIMERS > TRL_MAX_TIMERS) begin : g_bad_num
    $error("NUM_TIMERS must lie in 1..4");
  end

  // address decode, shared by read and write paths
  function automatic trl_dec_t decode(input logic [TRL_ADDR_W-1:0] a);
    logic [12:0] rel;
    rel         = a - TRL_OFS_CUR0;
    decode.idx  = rel[7:6];
    decode.kind = rel[5:4];
    decode.hit  = (a >= TRL_OFS_CUR0) && (rel[12:8] == 5'h00) && (rel[3:0] == 4'h0)
                  && (rel[5:4] != 2'h3) && ({30'h0, rel[7:6]} < NUM_TIMERS);
  endfunction

  // per-timer state
  logic [NUM_TIMERS-1:0]       hold;
  logic [NUM_TIMERS-1:0][30:0] reload;
  logic [NUM_TIMERS-1:0]       load;
  logic [NUM_TIMERS-1:0]       mask;
  logic [NUM_TIMERS-1:0][3:0]  level;
  logic [NUM_TIMERS-1:0][7:0]  vec;
  logic [NUM_TIMERS-1:0]       pend;
  logic [NUM_TIMERS-1:0]       insvc;
  logic [NUM_TIMERS-1:0]       next_hold;
  logic [NUM_TIMERS-1:0][30:0] next_reload;
  logic [NUM_TIMERS-1:0]       next_load;
  logic [NUM_TIMERS-1:0]       next_mask;
  logic [NUM_TIMERS-1:0][3:0]  next_level;
  logic [NUM_TIMERS-1:0][7:0]  next_vec;
  logic [NUM_TIMERS-1:0]       next_pend;
  logic [NUM_TIMERS-1:0]       next_insvc;

  // channel status gathered from the interfaces
  logic [NUM_TIMERS-1:0][30:0] cnt;
  logic [NUM_TIMERS-1:0]       tog;
  logic [NUM_TIMERS-1:0]       expire;

  // output registers
  logic [TRL_DATA_W-1:0] next_prdata;
  logic                  next_pslverr;
  logic [NUM_TIMERS-1:0] next_irq_req;
  logic                  next_best_valid;
  logic [TRL_IDX_W-1:0]  next_best_idx;
  logic [3:0]            next_best_level;
  logic                  next_ack_done;
  logic [7:0]            next_ack_vector;

  trl_dec_t dec;
  logic     setup;
  logic     wr_acc;
  logic     ack_ok;
  logic     eoi_ok;

  assign dec    = decode(paddr);
  assign setup  = psel && !penable;
  // zero wait states: the access phase always completes on its first edge
  assign pready = 1'b1;
  assign wr_acc = psel && penable && pwrite && dec.hit;
  assign ack_ok = ack_valid && ({30'h0, ack_idx} < NUM_TIMERS);
  assign eoi_ok = eoi_valid && ({30'h0, eoi_idx} < NUM_TIMERS);

  for (genvar g = 0; g < NUM_TIMERS; g++) begin : g_chan
    trl_chan_if ch ();
    assign ch.hold   = hold[g];
    assign ch.reload = reload[g];
    assign ch.load   = load[g];
    assign cnt[g]    = ch.count;
    assign tog[g]    = ch.toggle;
    assign expire[g] = ch.expire;

    trl_timer_chan u_chan (
      .pclk    (pclk),
      .presetn (presetn),
      .tick    (tick),
      .ch      (ch.chan)
    );
  end

  // register writes, pending and in-service bookkeeping
  always_comb begin
    next_hold   = hold;
    next_reload = reload;
    next_load   = '0;
    next_mask   = mask;
    next_level  = level;
    next_vec    = vec;
    next_pend   = pend;
    next_insvc  = insvc;
    for (int i = 0; i < NUM_TIMERS; i++) begin
      if (wr_acc && dec.idx == TRL_IDX_W'(i)) begin
        if (dec.kind == TRL_KIND_BASE) begin
          next_reload[i] = pwdata[TRL_COUNT_W-1:0];
          next_hold[i]   = pwdata[TRL_HOLD_BIT];
          next_load[i]   = hold[i] && !pwdata[TRL_HOLD_BIT];
        end else if (dec.kind == TRL_KIND_VP) begin
          next_mask[i]  = pwdata[TRL_MASK_BIT];
          next_level[i] = pwdata[TRL_LEVEL_LSB +: TRL_LEVEL_W];
          next_vec[i]   = pwdata[TRL_VEC_LSB +: TRL_VEC_W];
        end
      end
      if (ack_ok && ack_idx == TRL_IDX_W'(i) && pend[i]) begin
        next_pend[i]  = 1'b0;
        next_insvc[i] = 1'b1;
      end
      if (eoi_ok && eoi_idx == TRL_IDX_W'(i)) begin
        next_insvc[i] = 1'b0;
      end
      // an expiry in the acknowledge cycle must not be lost
      if (expire[i]) begin
        next_pend[i] = 1'b1;
      end
    end
  end

  // requests and arbitration, computed from registered state
  always_comb begin
    next_best_valid = 1'b0;
    next_best_idx   = '0;
    next_best_level = 4'h0;
    for (int i = 0; i < NUM_TIMERS; i++) begin
      // pending stays latched under mask, so unmasking raises it again
      next_irq_req[i] = pend[i] && !mask[i] && (level[i] != 4'h0);
      // ties go to the lowest index
      if (next_irq_req[i] && (!next_best_valid || level[i] > next_best_level)) begin
        next_best_valid = 1'b1;
        next_best_idx   = TRL_IDX_W'(i);
        next_best_level = level[i];
      end
    end
    next_ack_done   = ack_ok;
    next_ack_vector = ack_ok ? vec[ack_idx] : ack_vector;
  end

  // read data is captured in the setup cycle, so it stands through the access phase
  always_comb begin
    next_prdata  = prdata;
    next_pslverr = 1'b0;
    if (setup) begin
      next_prdata  = '0;
      next_pslverr = !dec.hit;
      if (dec.hit && !pwrite) begin
        unique case (dec.kind)
          TRL_KIND_CUR: begin
            next_prdata[TRL_TOGGLE_BIT]         = tog[dec.idx];
            next_prdata[TRL_COUNT_W-1:0]        = cnt[dec.idx];
          end
          TRL_KIND_BASE: begin
            next_prdata[TRL_HOLD_BIT]           = hold[dec.idx];
            next_prdata[TRL_COUNT_W-1:0]        = reload[dec.idx];
          end
          TRL_KIND_VP: begin
            next_prdata[TRL_MASK_BIT]           = mask[dec.idx];
            next_prdata[TRL_ACT_BIT]            = pend[dec.idx] || insvc[dec.idx];
            next_prdata[TRL_LEVEL_LSB +: TRL_LEVEL_W] = level[dec.idx];
            next_prdata[TRL_VEC_LSB +: TRL_VEC_W]     = vec[dec.idx];
          end
          default: next_prdata = '0;
        endcase
      end
    end else if (!psel) begin
      next_prdata = '0;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      hold   <= {NUM_TIMERS{TRL_HOLD_RST}};
      reload <= {NUM_TIMERS{TRL_RELOAD_RST}};
      load   <= '0;
      mask   <= {NUM_TIMERS{TRL_MASK_RST}};
      level  <= {NUM_TIMERS{TRL_LEVEL_RST}};
      vec    <= {NUM_TIMERS{TRL_VEC_RST}};
      pend   <= '0;
      insvc  <= '0;
    end else begin
      hold   <= next_hold;
      reload <= next_reload;
      load   <= next_load;
      mask   <= next_mask;
      level  <= next_level;
      vec    <= next_vec;
      pend   <= next_pend;
      insvc  <= next_insvc;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata         <= '0;
      pslverr        <= 1'b0;
      irq_req        <= '0;
      irq_best_valid <= 1'b0;
      irq_best_idx   <= '0;
      irq_best_level <= 4'h0;
      ack_done       <= 1'b0;
      ack_vector     <= 8'h00;
    end else begin
      prdata         <= next_prdata;
      pslverr        <= next_pslverr;
      irq_req        <= next_irq_req;
      irq_best_valid <= next_best_valid;
      irq_best_idx   <= next_best_idx;
      irq_best_level <= next_best_level;
      ack_done       <= next_ack_done;
      ack_vector     <= next_ack_vector;
    end
  end

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  property p_act_read;
    setup && !pwrite && dec.hit && dec.kind == TRL_KIND_VP
      |=> prdata[TRL_ACT_BIT] == ($past(pend[dec.idx]) || $past(insvc[dec.idx]));
  endproperty
  a_act_read: assert property (p_act_read) else $error("activity bit mismatch");

  property p_ack_vector;
    ack_ok |=> ack_done && ack_vector == $past(vec[ack_idx]);
  endproperty
  a_ack_vector: assert property (p_ack_vector) else $error("wrong vector on acknowledge");

  for (genvar k = 0; k < NUM_TIMERS; k++) begin : g_chk
    property p_mask_blocks;
      $past(mask[k]) |-> !irq_req[k];
    endproperty
    a_mask_blocks: assert property (p_mask_blocks) else $error("request while masked");

    property p_level_zero;
      $past(level[k]) == 4'h0 |-> !irq_req[k];
    endproperty
    a_level_zero: assert property (p_level_zero) else $error("request at level zero");

    property p_unmask_fires;
      $fell(mask[k]) && pend[k] && level[k] != 4'h0 |=> irq_req[k];
    endproperty
    a_unmask_fires: assert property (p_unmask_fires) else $error("unmask lost pending");

    property p_expire_pends;
      expire[k] |=> pend[k];
    endproperty
    a_expire_pends: assert property (p_expire_pends) else $error("expiry not pending");

    property p_best_level;
      irq_req[k] |-> irq_best_valid && irq_best_level >= $past(level[k]);
    endproperty
    a_best_level: assert property (p_best_level) else $error("lower level won");

    sequence s_release;
      wr_acc && dec.idx == TRL_IDX_W'(k) && dec.kind == TRL_KIND_BASE
        && hold[k] && !pwdata[TRL_HOLD_BIT];
    endsequence
    property p_release_loads;
      s_release |=> load[k] ##1 (cnt[k] == $past(reload[k]) && !tog[k]);
    endproperty
    a_release_loads: assert property (p_release_loads) else $error("release did not load");
  end

endmodule : trl_timer_block

`default_nettype wire

/* verification/test_trl_timer_block.sv */
// test_trl_timer_block: directed apb bench for the reload timer block.
// assumes zero-wait apb slave, bench drives tick, acknowledge and end of service itself.
`default_nettype none

module test_trl_timer_block
  import trl_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;

  logic        pclk = 1'b0;
  logic        presetn;
  logic        psel;
  logic        penable;
  logic        pwrite;
  logic [12:0] paddr;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic        tick;
  logic [3:0]  irq_req;
  logic        irq_best_valid;
  logic [1:0]  irq_best_idx;
  logic [3:0]  irq_best_level;
  logic        ack_valid;
  logic [1:0]  ack_idx;
  logic        eoi_valid;
  logic [1:0]  eoi_idx;
  logic        ack_done;
  logic [7:0]  ack_vector;
  int          bad_count;
  int          n_checks;
  logic [31:0] rd;
  logic        er;

  trl_timer_block #(.NUM_TIMERS(4)) u_trl_timer_block (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .tick(tick), .irq_req(irq_req), .irq_best_valid(irq_best_valid),
    .irq_best_idx(irq_best_idx), .irq_best_level(irq_best_level),
    .ack_valid(ack_valid), .ack_idx(ack_idx), .eoi_valid(eoi_valid), .eoi_idx(eoi_idx),
    .ack_done(ack_done), .ack_vector(ack_vector)
  );

  always #25 pclk = ~pclk;

  function automatic logic [12:0] a_reg(input int n, input logic [12:0] base);
    return 13'(base + TRL_STRIDE * n);
  endfunction

  task automatic close_out();
    $display("checks %0d mismatches %0d", n_checks, bad_count);
    if (bad_count == 0 && n_checks > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      bad_count++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // one full transfer; answer taken at the rising edge that sees pready, released right after
  task automatic apb(input logic wr, input logic [12:0] a, input logic [31:0] d);
    int i;
    @(posedge pclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    for (i = 0; i < 20; i++) begin
      @(posedge pclk);
      if (pready === 1'b1) break;
    end
    if (i == 20) begin
      bad_count++;
      close_out();
    end
    rd = prdata;
    er = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic rd_chk(input logic [12:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0000_0000);
    chk(rd, exp);
    chk({31'h0, er}, 32'h0000_0000);
  endtask

  task automatic ticks(input int n);
    repeat (n) begin
      @(posedge pclk);
      tick <= 1'b1;
      @(posedge pclk);
      tick <= 1'b0;
    end
    repeat (3) @(posedge pclk);
  endtask

  // request lines settle a cycle or two after the register write
  task automatic wait_irq(input int i, input logic v);
    int k;
    for (k = 0; k < 10; k++) begin
      @(negedge pclk);
      if (irq_req[i] === v) break;
    end
    chk({31'h0, irq_req[i]}, {31'h0, v});
    // a request that never settles ends the run
    if (k == 10) close_out();
  endtask

  initial begin
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 13'h0000;
    pwdata = 32'h0000_0000;
    tick = 1'b0;
    ack_valid = 1'b0;
    ack_idx = 2'h0;
    eoi_valid = 1'b0;
    eoi_idx = 2'h0;
    bad_count = 0;
    n_checks = 0;
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    // reset state, all four timers
    for (int n = 0; n < 4; n++) begin
      rd_chk(a_reg(n, TRL_OFS_VP0), 32'h8000_0000);
      rd_chk(a_reg(n, TRL_OFS_BASE0), 32'h0000_0000);
    end
    chk({31'h0, irq_req[0]}, 32'h0000_0000);
    // full 31-bit reload field plus hold
    apb(1'b1, a_reg(0, TRL_OFS_BASE0), 32'hFFFF_FFFF);
    rd_chk(a_reg(0, TRL_OFS_BASE0), 32'hFFFF_FFFF);
    apb(1'b1, a_reg(0, TRL_OFS_BASE0), 32'h8000_0005);
    rd_chk(a_reg(0, TRL_OFS_BASE0), 32'h8000_0005);
    // held timer ignores ticks; timers 1..3 expire meanwhile
    ticks(3);
    rd_chk(a_reg(0, TRL_OFS_CUR0), 32'h0000_0000);
    // hold 1 -> 0 loads count and clears toggle
    apb(1'b1, a_reg(0, TRL_OFS_BASE0), 32'h0000_0005);
    repeat (3) @(posedge pclk);
    rd_chk(a_reg(0, TRL_OFS_CUR0), 32'h0000_0005);
    ticks(1);
    rd_chk(a_reg(0, TRL_OFS_CUR0), 32'h0000_0004);
    ticks(3);
    rd_chk(a_reg(0, TRL_OFS_CUR0), 32'h0000_0001);
    ticks(1);
    rd_chk(a_reg(0, TRL_OFS_CUR0), 32'h8000_0005);
    // toggle is now one, so a second release must visibly clear it
    apb(1'b1, a_reg(0, TRL_OFS_BASE0), 32'h8000_0005);
    apb(1'b1, a_reg(0, TRL_OFS_BASE0), 32'h0000_0005);
    repeat (3) @(posedge pclk);
    rd_chk(a_reg(0, TRL_OFS_CUR0), 32'h0000_0005);
    rd_chk(a_reg(0, TRL_OFS_VP0), 32'hC000_0000);
    chk({31'h0, irq_req[0]}, 32'h0000_0000);
    // unmasked but level zero stays silent
    apb(1'b1, a_reg(0, TRL_OFS_VP0), 32'h0000_005A);
    repeat (4) @(posedge pclk);
    chk({31'h0, irq_req[0]}, 32'h0000_0000);
    apb(1'b1, a_reg(0, TRL_OFS_VP0), 32'h0003_005A);
    wait_irq(0, 1'b1);
    chk({28'h0, irq_best_valid, irq_best_idx, 1'b0}, 32'h0000_0008);
    chk({28'h0, irq_best_level}, 32'h0000_0003);
    rd_chk(a_reg(0, TRL_OFS_VP0), 32'h4003_005A);
    apb(1'b1, a_reg(0, TRL_OFS_VP0), 32'h8003_005A);
    wait_irq(0, 1'b0);
    apb(1'b1, a_reg(0, TRL_OFS_VP0), 32'h0003_005A);
    wait_irq(0, 1'b1);
    // acknowledge returns the vector, in service keeps activity up
    @(posedge pclk);
    ack_valid <= 1'b1;
    ack_idx   <= 2'h0;
    @(posedge pclk);
    ack_valid <= 1'b0;
    @(negedge pclk);
    chk({31'h0, ack_done}, 32'h0000_0001);
    chk({24'h0, ack_vector}, 32'h0000_005A);
    wait_irq(0, 1'b0);
    rd_chk(a_reg(0, TRL_OFS_VP0), 32'h4003_005A);
    @(posedge pclk);
    eoi_valid <= 1'b1;
    eoi_idx   <= 2'h0;
    @(posedge pclk);
    eoi_valid <= 1'b0;
    rd_chk(a_reg(0, TRL_OFS_VP0), 32'h0003_005A);
    // competing sources: highest level wins, then lowest index on a tie
    apb(1'b1, a_reg(1, TRL_OFS_VP0), 32'h000F_0011);
    apb(1'b1, a_reg(2, TRL_OFS_VP0), 32'h0002_0022);
    repeat (3) @(posedge pclk);
    chk({28'h0, irq_best_valid, irq_best_idx, 1'b0}, 32'h0000_000A);
    chk({28'h0, irq_best_level}, 32'h0000_000F);
    apb(1'b1, a_reg(2, TRL_OFS_VP0), 32'h000F_0022);
    repeat (3) @(posedge pclk);
    chk({28'h0, irq_best_valid, irq_best_idx, 1'b0}, 32'h0000_000A);
    apb(1'b1, a_reg(1, TRL_OFS_VP0), 32'h0001_0011);
    repeat (3) @(posedge pclk);
    chk({28'h0, irq_best_valid, irq_best_idx, 1'b0}, 32'h0000_000C);
    chk({28'h0, irq_best_level}, 32'h0000_000F);
    // unmapped destination slot refuses both directions
    apb(1'b1, 13'h1130, 32'hFFFF_FFFF);
    chk({31'h0, er}, 32'h0000_0001);
    apb(1'b0, 13'h1130, 32'h0000_0000);
    chk({31'h0, er}, 32'h0000_0001);
    chk(rd, 32'h0000_0000);
    rd_chk(a_reg(0, TRL_OFS_BASE0), 32'h0000_0005);
    close_out();
  end

endmodule // test_trl_timer_block

`default_nettype wire
